/* File: design/mpfc_top.sv */
/*
 * Frame-based flow control for a 10/100 MAC: pause generation with
 * repause and resume-on-empty modes, received pause and low-priority
 * pause handling, control frame filtering and wait-after-win.
 * Assumes the MAC core parses received headers, retries collided
 * frames with normal backoff, and reports FIFO state on this clock.
 */
// Overview of operation
// - Send full delay, count it minus low bits
// - Repause on expiry while receive FIFO holds data
// - Resume frame with zero time once FIFO empties
// - Delay below 32: send, do not load counter
// - Delay below 32 repause: back to back pauses
// - Delay below 32 resume mode: no resume frame
// - Byte 19 bit 2 zero honors received pause
// - Byte 19 bits 4,3 select resume, repause
// - Byte 19 bit 5 drops multicast control frames
// - Pause time from bytes 16 low, 17 high
// - Full pause halts all; low pause halts queue
// - Low pause still sends frames in transmit FIFO
// - Low-priority pause received only, never generated
// - Newest control frame replaces earlier effect
// - Full then low pause resumes high priority
// - Low then full pause stops high at once
// - Pause leaves command unit status unchanged
// - Low three priority bits against threshold
// - Maximum threshold makes every frame full pause
// - Collided control frame retried after normal backoff
// - Wait-after-win stretches gap to one to two slots
// - Received time loads 16-bit slot down counter
// - Threshold crossing congests until FIFO empty
// - Type 88-08 at multicast or own address
// - Own expiry ignores low five delay bits
`timescale 1ns/1ps
module mpfc_top (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cfg_load_i,
    input wire mpfc_pkg::mpfc_cfg_type cfg_i,
    input wire logic [47:0] own_addr_i,
    input wire mpfc_pkg::mpfc_rxhdr_type rx_hdr_i,
    input wire logic rx_fifo_over_thresh_i,
    input wire logic rx_fifo_empty_i,
    input wire logic tx_busy_i,
    input wire logic tx_ctrl_done_i,
    input wire logic tx_collision_i,
    input wire logic tx_done_i,
    input wire logic [1:0] command_unit_status_i,
    output mpfc_pkg::mpfc_txreq_type pause_req_o,
    output logic rx_forward_o,
    output logic rx_drop_o,
    output logic tx_inhibit_all_o,
    output logic tx_inhibit_low_priority_queue_o,
    output logic gap_hold_o,
    output logic paused_status_o,
    output logic sending_pause_status_o,
    output logic [1:0] command_unit_status_o
);
    typedef struct packed {
        mpfc_pkg::mpfc_cfg_type cfg;
        mpfc_pkg::mpfc_send_type send;
        logic congested;
        logic own_armed;
        logic resume_pending;
        logic low_pause;
        mpfc_pkg::mpfc_txreq_type req;
        logic fwd;
        logic drop;
        logic inh_all;
        logic inh_low;
        logic gap_hold;
        logic [1:0] command_unit_status;
    } mpfc_state_type;

    mpfc_state_type st_reg;
    mpfc_state_type st_next;

    logic rx_load;
    logic [15:0] rx_count;
    logic slot_tick;
    logic own_load;
    logic [15:0] own_value;
    logic [15:0] own_count;
    logic wait_hold;
    logic is_ctrl;
    logic is_full_pause;
    logic honor;
    logic repause;
    logic resume_mode;
    logic short_delay;

    // Configured settings only move on configure completion
    assign honor = ~st_reg.cfg.byte19[mpfc_pkg::CFG19_HONOR_BIT];
    assign repause = st_reg.cfg.byte19[mpfc_pkg::CFG19_REPAUSE_BIT];
    assign resume_mode = st_reg.cfg.byte19[mpfc_pkg::CFG19_RESUME_BIT];
    assign short_delay = (st_reg.cfg.pause_time_setting & mpfc_pkg::DELAY_MASK)
        == mpfc_pkg::ZERO_TIME;

    // Control frame recognition by type and destination
    assign is_ctrl = rx_hdr_i.valid
        && rx_hdr_i.type_field == mpfc_pkg::CTRL_TYPE
        && (rx_hdr_i.dest_addr == mpfc_pkg::CTRL_MCAST
            || rx_hdr_i.dest_addr == own_addr_i);
    // Only three priority bits count; threshold 7 makes all full
    assign is_full_pause = rx_hdr_i.priority_byte[2:0] <= st_reg.cfg.prio_threshold;

    // Received pause reloads the partner timer; a low pause clears it
    assign rx_load = is_ctrl && honor;
    mpfc_slot_timer u_rx_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(rx_load),
        .value_i(is_full_pause ? rx_hdr_i.time_param : mpfc_pkg::ZERO_TIME),
        .tick_o(slot_tick),
        .count_o(rx_count)
    );

    // Own expiry timer runs on the delay with its low bits cleared
    assign own_value = st_reg.cfg.pause_time_setting & mpfc_pkg::DELAY_MASK;
    assign own_load = tx_ctrl_done_i && st_reg.send == mpfc_pkg::SEND_WAIT_TX
        && st_reg.req.time_param != mpfc_pkg::ZERO_TIME && !short_delay;
    mpfc_slot_timer u_own_timer (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .load_i(own_load),
        .value_i(own_value),
        .tick_o(),
        .count_o(own_count)
    );

    // Gap stretch; collided control frames retry in the core's backoff
    mpfc_backoff u_backoff (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .enable_i(st_reg.cfg.wait_after_win),
        .tick_i(slot_tick),
        .collision_i(tx_collision_i),
        .tx_done_i(tx_done_i),
        .hold_o(wait_hold)
    );

    // Pause sender, congestion tracking and receive-side effects
    always_comb begin
        st_next = st_reg;
        st_next.fwd = 1'b0;
        st_next.drop = 1'b0;
        st_next.gap_hold = wait_hold;
        // Registered copy of the input, one cycle late; pause frames never touch it
        st_next.command_unit_status = command_unit_status_i;

        if (cfg_load_i) begin
            st_next.cfg = cfg_i;
        end

        // Congestion stays set until the FIFO is fully empty
        if (rx_fifo_over_thresh_i) begin
            st_next.congested = 1'b1;
        end else if (rx_fifo_empty_i) begin
            st_next.congested = 1'b0;
        end

        case (st_reg.send)
            mpfc_pkg::SEND_IDLE: begin
                if (st_reg.congested || rx_fifo_over_thresh_i) begin
                    // Full setting goes in the frame; only pauses, never low
                    st_next.req.req = 1'b1;
                    st_next.req.time_param = st_reg.cfg.pause_time_setting;
                    st_next.send = mpfc_pkg::SEND_WAIT_TX;
                end
            end
            mpfc_pkg::SEND_WAIT_TX: begin
                // Request is queued behind the current frame by the core
                if (tx_ctrl_done_i) begin
                    st_next.req.req = 1'b0;
                    if (st_reg.req.time_param == mpfc_pkg::ZERO_TIME) begin
                        st_next.send = mpfc_pkg::SEND_IDLE;
                        st_next.own_armed = 1'b0;
                    end else begin
                        st_next.send = mpfc_pkg::SEND_PAUSED;
                        st_next.own_armed = !short_delay;
                        // No resume frame follows a short delay
                        st_next.resume_pending = resume_mode && !short_delay;
                    end
                end
            end
            mpfc_pkg::SEND_PAUSED: begin
                if (st_reg.resume_pending && rx_fifo_empty_i) begin
                    st_next.req.req = 1'b1;
                    st_next.req.time_param = mpfc_pkg::ZERO_TIME;
                    st_next.resume_pending = 1'b0;
                    st_next.send = mpfc_pkg::SEND_WAIT_TX;
                end else if (short_delay) begin
                    // Back to back pauses saturate the link; avoid this setup
                    if (repause && !rx_fifo_empty_i) begin
                        st_next.req.req = 1'b1;
                        st_next.req.time_param = st_reg.cfg.pause_time_setting;
                        st_next.send = mpfc_pkg::SEND_WAIT_TX;
                    end else if (!st_reg.congested) begin
                        st_next.send = mpfc_pkg::SEND_IDLE;
                    end
                end else if (st_reg.own_armed && own_count == mpfc_pkg::ZERO_TIME) begin
                    st_next.own_armed = 1'b0;
                    if (repause && !rx_fifo_empty_i) begin
                        st_next.req.req = 1'b1;
                        st_next.req.time_param = st_reg.cfg.pause_time_setting;
                        st_next.send = mpfc_pkg::SEND_WAIT_TX;
                    end else begin
                        // Expired: go back to watching the FIFO
                        st_next.send = mpfc_pkg::SEND_IDLE;
                        st_next.resume_pending = 1'b0;
                    end
                end
            end
            default: begin
                st_next.send = mpfc_pkg::SEND_IDLE;
            end
        endcase

        // Newest received control frame decides the kind of pause
        if (rx_load) begin
            st_next.low_pause = !is_full_pause;
        end
        if (is_ctrl) begin
            // Own-address control frames are always passed on
            if (st_reg.cfg.byte19[mpfc_pkg::CFG19_DROP_BIT]
                && rx_hdr_i.dest_addr != own_addr_i) begin
                st_next.drop = 1'b1;
            end else begin
                st_next.fwd = 1'b1;
            end
        end else if (rx_hdr_i.valid) begin
            st_next.fwd = 1'b1;
        end

        // Full pause stops the MAC; low pause stops only that queue,
        // frames already in the transmit FIFO keep going
        st_next.inh_all = honor && (rx_load ? (is_full_pause
            && rx_hdr_i.time_param != mpfc_pkg::ZERO_TIME)
            : (!st_reg.low_pause && rx_count != mpfc_pkg::ZERO_TIME));
        st_next.inh_low = honor && (rx_load ? !is_full_pause : st_reg.low_pause);
        if (!honor) begin
            st_next.low_pause = 1'b0;
        end
    end

    // Single register stage for all state
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
            st_reg.cfg.byte19 <= mpfc_pkg::CFG19_RESET;
            st_reg.cfg.pause_time_setting <= mpfc_pkg::PAUSE_TIME_RESET;
            st_reg.cfg.prio_threshold <= mpfc_pkg::PRIO_THRESH_RESET;
            st_reg.cfg.wait_after_win <= mpfc_pkg::WAIT_AFTER_WIN_RESET;
            st_reg.send <= mpfc_pkg::SEND_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pause_req_o = st_reg.req;
    assign rx_forward_o = st_reg.fwd;
    assign rx_drop_o = st_reg.drop;
    assign tx_inhibit_all_o = st_reg.inh_all;
    assign tx_inhibit_low_priority_queue_o = st_reg.inh_low;
    assign gap_hold_o = st_reg.gap_hold;
    assign paused_status_o = st_reg.inh_all | st_reg.inh_low;
    assign sending_pause_status_o = st_reg.send == mpfc_pkg::SEND_WAIT_TX;
    assign command_unit_status_o = st_reg.command_unit_status;
endmodule

/* File: design/mpfc_pkg.sv */
/*
 * Package for the MAC pause flow control block: configuration byte
 * positions, reset values, timing counts, carrier structs and states.
 * Assumes one 100 MHz MAC clock; the slot-time divide count SLOT_CYCLES is worked out from it here.
 */
package mpfc_pkg;
    // Configuration byte 19 bit positions
    localparam int CFG19_HONOR_BIT = 2;
    localparam int CFG19_REPAUSE_BIT = 3;
    localparam int CFG19_RESUME_BIT = 4;
    localparam int CFG19_DROP_BIT = 5;
    // Reset values of the settings
    localparam logic [7:0] CFG19_RESET = 8'h00;
    localparam logic [15:0] PAUSE_TIME_RESET = 16'h4000;
    localparam logic [2:0] PRIO_THRESH_RESET = 3'h7;
    localparam logic WAIT_AFTER_WIN_RESET = 1'b0;
    // Own expiry count ignores the low five bits
    localparam logic [15:0] DELAY_MASK = 16'hffe0;
    localparam logic [15:0] ZERO_TIME = 16'h0000;
    // Control frame recognition
    localparam logic [15:0] CTRL_TYPE = 16'h8808;
    localparam logic [47:0] CTRL_MCAST = 48'h0180c2000001;
    // Slot time: 512 bit times at 100 Mb/s
    localparam int CLOCK_MHZ = 100;
    localparam int SLOT_TIME_NS = 5120;
    localparam int SLOT_CYCLES = (SLOT_TIME_NS * CLOCK_MHZ) / 1000;
    localparam int SLOT_CW = 10;

    typedef struct packed {
        logic [7:0] byte19;
        logic [15:0] pause_time_setting;
        logic [2:0] prio_threshold;
        logic wait_after_win;
    } mpfc_cfg_type;

    // A parsed received frame header, presented with valid
    typedef struct packed {
        logic valid;
        logic [47:0] dest_addr;
        logic [15:0] type_field;
        logic [15:0] time_param;
        logic [7:0] priority_byte;
    } mpfc_rxhdr_type;

    // Request to the transmit path for a generated pause frame
    typedef struct packed {
        logic req;
        logic [15:0] time_param;
    } mpfc_txreq_type;

    typedef enum logic [1:0] {
        SEND_IDLE,
        SEND_WAIT_TX,
        SEND_PAUSED
    } mpfc_send_type;
endpackage

/* File: design/mpfc_slot_timer.sv */
/*
 * Slot-time tick divider and a 16-bit slot-time down counter.
 * Assumes a synchronous active-high reset on the single MAC clock.
 */
`timescale 1ns/1ps
module mpfc_slot_timer (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [15:0] value_i,
    output logic tick_o,
    output logic [15:0] count_o
);
    typedef struct packed {
        logic [mpfc_pkg::SLOT_CW-1:0] div;
        logic tick;
        logic [15:0] count;
    } mpfc_tmr_type;

    mpfc_tmr_type st_reg;
    mpfc_tmr_type st_next;

    // Divider makes a one-cycle slot pulse; load wins over decrement
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.div == mpfc_pkg::SLOT_CW'(mpfc_pkg::SLOT_CYCLES - 1)) begin
            st_next.div = '0;
            st_next.tick = 1'b1;
        end else begin
            st_next.div = st_reg.div + 1'b1;
        end
        if (load_i) begin
            st_next.count = value_i;
        end else if (st_reg.tick && st_reg.count != 16'h0000) begin
            st_next.count = st_reg.count - 16'h0001;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tick_o = st_reg.tick;
    assign count_o = st_reg.count;
endmodule

/* File: design/mpfc_backoff.sv */
/*
 * Wait-after-win gap stretcher for half duplex. After a frame that
 * collided earlier goes out cleanly, the next gap is one to two slot times.
 * Assumes the MAC core reports collisions and good transmit ends.
 */
`timescale 1ns/1ps
module mpfc_backoff (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic tick_i,
    input wire logic collision_i,
    input wire logic tx_done_i,
    output logic hold_o
);
    typedef struct packed {
        logic collided;
        logic armed;
        logic hold;
    } mpfc_bo_type;

    mpfc_bo_type st_reg;
    mpfc_bo_type st_next;

    // Hold lasts from the good end until the second slot tick,
    // so at least one whole slot time passes
    always_comb begin
        st_next = st_reg;
        if (collision_i) begin
            st_next.collided = 1'b1;
        end
        if (tx_done_i && st_reg.collided) begin
            st_next.collided = collision_i;
            if (enable_i) begin
                st_next.hold = 1'b1;
                st_next.armed = 1'b0;
            end
        end else if (st_reg.hold && tick_i) begin
            if (st_reg.armed) begin
                st_next.hold = 1'b0;
            end
            st_next.armed = 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign hold_o = st_reg.hold;
endmodule

/* File: bench/mpfc_top_sva.sv */
/* Assertions for the pause flow control top.
   Assumes binding to mpfc_top and a shadow of the settings it holds. */
`timescale 1ns/1ps
module mpfc_top_sva (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic cfg_load_i,
    input wire mpfc_pkg::mpfc_cfg_type cfg_i,
    input wire logic [47:0] own_addr_i,
    input wire mpfc_pkg::mpfc_rxhdr_type rx_hdr_i,
    input wire logic tx_ctrl_done_i,
    input wire logic [1:0] command_unit_status_i,
    input wire mpfc_pkg::mpfc_txreq_type pause_req_o,
    input wire logic rx_forward_o,
    input wire logic rx_drop_o,
    input wire logic tx_inhibit_all_o,
    input wire logic tx_inhibit_low_priority_queue_o,
    input wire logic [1:0] command_unit_status_o
);
    mpfc_pkg::mpfc_cfg_type cfg_reg;
    logic ctrl, honor, full, drop_me, inh, low;
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Shadow of the settings, taken when configure completes
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cfg_reg <= {mpfc_pkg::CFG19_RESET, mpfc_pkg::PAUSE_TIME_RESET,
                mpfc_pkg::PRIO_THRESH_RESET, mpfc_pkg::WAIT_AFTER_WIN_RESET};
        end else if (cfg_load_i) begin
            cfg_reg <= cfg_i;
        end
    end
    // Header classes; bench never loads settings with a header
    assign ctrl = rx_hdr_i.valid && rx_hdr_i.type_field == mpfc_pkg::CTRL_TYPE &&
        (rx_hdr_i.dest_addr == mpfc_pkg::CTRL_MCAST || rx_hdr_i.dest_addr == own_addr_i);
    assign honor = ctrl && !cfg_reg.byte19[mpfc_pkg::CFG19_HONOR_BIT];
    assign full = rx_hdr_i.priority_byte[2:0] <= cfg_reg.prio_threshold;
    assign drop_me = ctrl && cfg_reg.byte19[mpfc_pkg::CFG19_DROP_BIT] &&
        rx_hdr_i.dest_addr != own_addr_i;
    assign inh = tx_inhibit_all_o;
    assign low = tx_inhibit_low_priority_queue_o;

    a_drop_ctrl: assert property (drop_me |=> rx_drop_o && !rx_forward_o)
        else $error("control frame not dropped");
    a_forward_other: assert property (rx_hdr_i.valid && !drop_me |=> rx_forward_o && !rx_drop_o)
        else $error("frame not forwarded");
    a_full_pause: assert property (honor && full && rx_hdr_i.time_param != 16'h0000 |=> inh && !low)
        else $error("full pause not applied");
    a_low_pause: assert property (honor && !full |=> low && !inh)
        else $error("low pause not applied");
    a_zero_resume: assert property (honor && full && rx_hdr_i.time_param == 16'h0000 |=> !inh && !low)
        else $error("zero time did not release");
    a_honor_off: assert property (ctrl && !honor && !inh && !low |=> !inh && !low)
        else $error("pause honored while disabled");
    a_req_holds: assert property (pause_req_o.req && !tx_ctrl_done_i |=>
        pause_req_o.req && $stable(pause_req_o.time_param))
        else $error("pause request not held");
    a_req_release: assert property (pause_req_o.req && tx_ctrl_done_i |=> !pause_req_o.req)
        else $error("pause request not released");
    a_cu_echo: assert property (!$past(rst_i) |-> command_unit_status_o == $past(command_unit_status_i))
        else $error("command unit status altered");
endmodule

bind mpfc_top mpfc_top_sva mpfc_top_sva_i (.clock_i, .rst_i, .cfg_load_i, .cfg_i,
    .own_addr_i, .rx_hdr_i, .tx_ctrl_done_i, .command_unit_status_i, .pause_req_o,
    .rx_forward_o, .rx_drop_o, .tx_inhibit_all_o, .tx_inhibit_low_priority_queue_o,
    .command_unit_status_o);

/* File: bench/mpfc_link_partner.sv */
/* Transmit side model: sends each requested pause frame and reports it.
   Assumes one request at a time; slow_i stands for a data frame ahead. */
`timescale 1ns/1ps
module mpfc_link_partner (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire mpfc_pkg::mpfc_txreq_type pause_req_i,
    input wire logic slow_i,
    output logic tx_ctrl_done_o,
    output logic [7:0] frames_o,
    output logic [15:0] last_time_o
);
    logic [5:0] wait_reg;
    logic busy_reg, prev_reg;
    // One frame queued at a time
    always_ff @(posedge clock_i) begin
        tx_ctrl_done_o <= 1'b0;
        prev_reg <= pause_req_i.req;
        if (rst_i) begin
            frames_o <= 8'h00;
            last_time_o <= 16'h0000;
            busy_reg <= 1'b0;
        end else if (pause_req_i.req && !prev_reg) begin
            frames_o <= frames_o + 8'h01;
            last_time_o <= pause_req_i.time_param;
            wait_reg <= slow_i ? 6'h28 : 6'h02;
            busy_reg <= 1'b1;
        end else if (busy_reg) begin
            if (wait_reg == 6'h00) begin
                tx_ctrl_done_o <= 1'b1;
                busy_reg <= 1'b0;
            end
            wait_reg <= wait_reg - 6'h01;
        end
    end
endmodule

/* File: bench/test_mpfc_top.sv */
/* Self-checking bench for the pause flow control top.
   Assumes the partner model answers pause requests. */
`timescale 1ns/1ps
module test_mpfc_top;
    localparam logic [47:0] mc = mpfc_pkg::CTRL_MCAST;
    localparam logic [15:0] ct = mpfc_pkg::CTRL_TYPE;
    localparam logic [47:0] own = 48'h02a0b0c0d0e0;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic cfg_load_i = 1'b0;
    mpfc_pkg::mpfc_cfg_type cfg_i = '0;
    logic [47:0] own_addr_i = own;
    mpfc_pkg::mpfc_rxhdr_type rx_hdr_i = '0;
    logic rx_fifo_over_thresh_i = 1'b0;
    logic rx_fifo_empty_i = 1'b1;
    logic tx_busy_i = 1'b0;
    logic tx_collision_i = 1'b0;
    logic tx_done_i = 1'b0;
    logic [1:0] command_unit_status_i = 2'h0;
    logic slow_i = 1'b0;
    logic tx_ctrl_done_i, rx_forward_o, rx_drop_o, tx_inhibit_all_o, gap_hold_o;
    logic tx_inhibit_low_priority_queue_o, paused_status_o, sending_pause_status_o;
    logic [1:0] command_unit_status_o;
    mpfc_pkg::mpfc_txreq_type pause_req_o;
    logic [7:0] frames;
    logic [15:0] last_time;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    always #5 clock_i = ~clock_i;

    mpfc_top mpfc_top_i (.clock_i, .rst_i, .cfg_load_i, .cfg_i, .own_addr_i, .rx_hdr_i,
        .rx_fifo_over_thresh_i, .rx_fifo_empty_i, .tx_busy_i, .tx_ctrl_done_i,
        .tx_collision_i, .tx_done_i, .command_unit_status_i, .pause_req_o, .rx_forward_o,
        .rx_drop_o, .tx_inhibit_all_o, .tx_inhibit_low_priority_queue_o, .gap_hold_o,
        .paused_status_o, .sending_pause_status_o, .command_unit_status_o);
    mpfc_link_partner mpfc_link_partner_i (.clock_i, .rst_i, .pause_req_i(pause_req_o),
        .slow_i, .tx_ctrl_done_o(tx_ctrl_done_i), .frames_o(frames), .last_time_o(last_time));

    task automatic tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge clock_i) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            bad_count++;
            tally_and_finish;
        end
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    task automatic reset_dut;
        @(posedge clock_i);
        rst_i <= 1'b1;
        rx_fifo_over_thresh_i <= 1'b0;
        rx_fifo_empty_i <= 1'b1;
        slow_i <= 1'b0;
        wait_cyc(3);
        rst_i <= 1'b0;
    endtask

    task automatic configure(input logic [7:0] b, input logic [15:0] t, input logic [2:0] th,
        input logic w);
        @(posedge clock_i);
        cfg_i <= '{b, t, th, w};
        cfg_load_i <= 1'b1;
        @(posedge clock_i);
        cfg_load_i <= 1'b0;
    endtask

    // Outputs read after the third edge show the answer cycle
    task automatic send_hdr(input logic [47:0] d, input logic [15:0] ty, input logic [15:0] tm,
        input logic [7:0] pr);
        @(posedge clock_i);
        rx_hdr_i <= '{1'b1, d, ty, tm, pr};
        @(posedge clock_i);
        rx_hdr_i.valid <= 1'b0;
        @(posedge clock_i);
    endtask

    task automatic pulse_over;
        @(posedge clock_i);
        rx_fifo_over_thresh_i <= 1'b1;
        rx_fifo_empty_i <= 1'b0;
        @(posedge clock_i);
        rx_fifo_over_thresh_i <= 1'b0;
    endtask

    task automatic t_defaults;
        reset_dut;
        pulse_over;
        wait_cyc(20);
        check("frames", 16'h1, frames);
        check("pause time", 16'h4000, last_time);
        check("request", 16'h0, pause_req_o.req);
        send_hdr(mc, ct, 16'h0001, 8'h07);
        check("inhibit", 16'h1, tx_inhibit_all_o);
        wait_cyc(1100);
        check("inhibit end", 16'h0, tx_inhibit_all_o);
        $display("test defaults finished");
    endtask

    task automatic t_priority;
        reset_dut;
        configure(8'h00, 16'h0100, 3'h4, 1'b0);
        @(posedge clock_i) command_unit_status_i <= 2'h2;
        send_hdr(mc, ct, 16'h0005, 8'h04);
        check("all", 16'h1, tx_inhibit_all_o);
        send_hdr(mc, ct, 16'h0005, 8'h05);
        check("all", 16'h0, tx_inhibit_all_o);
        check("low", 16'h1, tx_inhibit_low_priority_queue_o);
        check("status", 16'h1, paused_status_o);
        send_hdr(own, ct, 16'h0005, 8'h0c);
        check("all", 16'h1, tx_inhibit_all_o);
        check("low", 16'h0, tx_inhibit_low_priority_queue_o);
        send_hdr(mc, ct, 16'h0000, 8'h00);
        check("all", 16'h0, tx_inhibit_all_o);
        check("cu", 16'h2, command_unit_status_o);
        $display("test priority finished");
    endtask

    task automatic t_filter;
        reset_dut;
        configure(8'h24, 16'h4000, 3'h7, 1'b0);
        send_hdr(mc, ct, 16'h0010, 8'h00);
        check("drop", 16'h1, rx_drop_o);
        check("all", 16'h0, tx_inhibit_all_o);
        send_hdr(own, ct, 16'h0010, 8'h00);
        check("forward own", 16'h1, rx_forward_o);
        send_hdr(mc, 16'h0800, 16'h0010, 8'h00);
        check("forward type", 16'h1, rx_forward_o);
        send_hdr(48'h0180c2000002, ct, 16'h0010, 8'h00);
        check("forward addr", 16'h1, rx_forward_o);
        $display("test filter finished");
    endtask

    task automatic t_short(input logic [7:0] mode);
        int n;
        reset_dut;
        configure(mode, 16'h0017, 3'h7, 1'b0);
        pulse_over;
        wait_cyc(100);
        check("short time", 16'h0017, last_time);
        check("burst", {15'h0, mode[3]}, {15'h0, frames > 8'h03});
        @(posedge clock_i) rx_fifo_empty_i <= 1'b1;
        wait_cyc(30);
        n = frames;
        wait_cyc(600);
        check("after empty", n[15:0], frames);
        check("last", 16'h0017, last_time);
        $display("test short delay finished");
    endtask

    task automatic t_resume;
        reset_dut;
        configure(8'h10, 16'h011f, 3'h7, 1'b0);
        @(posedge clock_i) slow_i <= 1'b1;
        pulse_over;
        wait_cyc(9);
        check("sending", 16'h1, sending_pause_status_o);
        wait_cyc(91);
        check("frames", 16'h1, frames);
        check("time", 16'h011f, last_time);
        @(posedge clock_i) rx_fifo_empty_i <= 1'b1;
        wait_cyc(100);
        check("frames", 16'h2, frames);
        check("resume time", 16'h0000, last_time);
        $display("test resume finished");
    endtask

    task automatic t_expiry;
        int n;
        reset_dut;
        configure(8'h08, 16'h003f, 3'h7, 1'b0);
        pulse_over;
        n = 0;
        while (tx_ctrl_done_i !== 1'b1 && n < 100) begin
            @(posedge clock_i);
            n++;
        end
        n = 0;
        while (frames < 8'h02 && n < 20000) begin
            @(posedge clock_i);
            n++;
        end
        // Timer holds 20h slots, not 3fh
        check("expiry window", 16'h1, {15'h0, n >= 30 * 512 && n <= 32 * 512 + 8});
        check("repause time", 16'h003f, last_time);
        $display("test expiry finished");
    endtask

    task automatic t_waw;
        int n;
        reset_dut;
        configure(8'h00, 16'h4000, 3'h7, 1'b1);
        @(posedge clock_i) tx_done_i <= 1'b1;
        @(posedge clock_i) tx_done_i <= 1'b0;
        wait_cyc(4);
        check("no hold", 16'h0, gap_hold_o);
        @(posedge clock_i) tx_collision_i <= 1'b1;
        @(posedge clock_i) tx_collision_i <= 1'b0;
        tx_done_i <= 1'b1;
        @(posedge clock_i) tx_done_i <= 1'b0;
        wait_cyc(3);
        check("hold", 16'h1, gap_hold_o);
        n = 0;
        while (gap_hold_o === 1'b1 && n < 1200) begin
            @(posedge clock_i);
            n++;
        end
        check("hold span", 16'h1, {15'h0, n >= 500 && n <= 1040});
        $display("test wait after win finished");
    endtask

    initial begin
        reset_dut;
        t_defaults;
        t_priority;
        t_filter;
        t_short(8'h08);
        t_short(8'h10);
        t_resume;
        t_waw;
        t_expiry;
        tally_and_finish;
    end
endmodule
